//--- hdl/eoc_ext_div.sv
`timescale 1ns/1ps
`include "eoc_cfg.svh"

module eoc_ext_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Oscillator side
  input wire logic ext_clk_pin,
  input wire logic run,
  // Peripheral side
  output logic tick
);
  import eoc_pkg::*;

  logic s1_ff, s2_ff, s3_ff;
  logic level_ff;
  logic [2:0] cnt_ff;
  logic tick_ff;
  logic rise;

  // ****************************************************************
  // Three-stage capture of the external clock
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else if (ce) begin
      s1_ff <= ext_clk_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A level is only taken once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
    end else if (ce && s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign rise = (s2_ff == s3_ff) && s3_ff && !level_ff;

  // ****************************************************************
  // Divide by eight
  // ****************************************************************
  // R8 divide by eight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
    end else if (ce) begin
      if (!run) begin
        cnt_ff <= 3'h0;
      end else if (rise) begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end

  // R17 one-cycle enable
  // R10 jitter up to one system cycle: the pulse lands on the third system edge after
  // the rise is first sampled, so no separate clock net reaches the peripherals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= run && rise && (cnt_ff == `EOC_DIV_LAST);
    end
  end

  assign tick = tick_ff;

endmodule : eoc_ext_div

//--- hdl/eoc_top.sv
`timescale 1ns/1ps
`include "eoc_cfg.svh"
// What this block does
// R1 - Five-bit trim field in calibration bits four to zero sets oscillator period.
// R2 - Calibration contents are undefined while clock recovery runs; reads not guaranteed.
// R3 - Software selects oscillator type and frequency control for the attached source.
// R4 - Crystal or resonator mode claims pins P0.2 and P0.3 as oscillator pins.
// R5 - Capacitor, RC or CMOS mode claims only P0.3 as second oscillator pin.
// R6 - Software should make the crossbar skip pins claimed by the oscillator.
// R7 - Software sets oscillator pins analog, or digital input for CMOS clock.
// R8 - External oscillator divided by eight is offered to timers and counter array.
// R9 - External clock for peripherals must not exceed the system clock.
// R10 - Divided clock is synchronised to system clock with half-cycle jitter; the code allows up to one system cycle.
// R11 - Software enables crystal, waits 1 ms, polls valid flag, then switches.
// R12 - Type field 11x selects crystal mode, low bit ignored.
// R13 - Type field 10x selects RC oscillator mode, low bit ignored.
// R14 - Frequency control must match crystal; 12 MHz needs 111b.
// R15 - Hardware sets the crystal valid flag once the oscillator settles.
// R16 - System clock runs from external oscillator only when select holds 01b.
// R17 - Divided clock reaches peripherals as one-cycle enable after synchroniser.

module eoc_top (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  // Register access
  input wire eoc_pkg::eoc_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  // Oscillator circuit
  input wire logic EXT_OSC_CLK,
  input wire logic AMP_SETTLED,
  input wire logic CLOCK_RECOVERY_EN,
  // Oscillator controls
  output logic [4:0] OSCILLATOR_TRIM_FIELD,
  output logic [2:0] EXT_OSC_TYPE_SELECT,
  output logic [2:0] EXT_FREQ_CONTROL,
  output logic OSC_PIN_ONE_CLAIM,
  output logic OSC_PIN_TWO_CLAIM,
  // Clocking results
  output logic SYSCLK_FROM_EXT,
  output logic EXT_DIV8_TICK
);
  import eoc_pkg::*;

  logic [4:0] trim_ff;
  logic [2:0] type_ff;
  logic [2:0] freq_ff;
  logic [1:0] clksel_ff;
  logic [7:0] rdata_ff;
  logic pin_one_ff, pin_two_ff;
  logic sys_ext_ff;
  logic a1_ff, a2_ff, a3_ff;
  logic amp_ff;
  eoc_xst_t xst_ff, nxt_xst;
  eoc_kind_t kind;
  eoc_xctl_t xctl_img;
  logic wr_cal, wr_xctl, wr_clksel;
  logic div_tick;
  logic [7:0] nxt_rdata;

  assign wr_cal = SFR_REQ.wr && SFR_REQ.addr == `EOC_ADDR_CAL;
  assign wr_xctl = SFR_REQ.wr && SFR_REQ.addr == `EOC_ADDR_XCTL;
  assign wr_clksel = SFR_REQ.wr && SFR_REQ.addr == `EOC_ADDR_CLKSEL;

  // R12 crystal decode
  // R13 RC decode
  assign kind = eoc_kind(type_ff);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // R1 trim field
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      trim_ff <= `EOC_CAL_RESET;
    end else if (CE && wr_cal) begin
      trim_ff <= SFR_REQ.wdata[`EOC_CAL_MSB:0];
    end
  end

  // Type and frequency are what software programs for its source
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      type_ff <= `EOC_TYPE_RESET;
      freq_ff <= `EOC_FREQ_RESET;
    end else if (CE && wr_xctl) begin
      type_ff <= SFR_REQ.wdata[`EOC_XCTL_TYPE_MSB:`EOC_XCTL_TYPE_LSB];
      freq_ff <= SFR_REQ.wdata[`EOC_XCTL_FREQ_MSB:`EOC_XCTL_FREQ_LSB];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      clksel_ff <= `EOC_CLKSEL_RESET;
    end else if (CE && wr_clksel) begin
      clksel_ff <= SFR_REQ.wdata[`EOC_CLKSEL_MSB:0];
    end
  end

  // R16 external system clock
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sys_ext_ff <= 1'b0;
    end else if (CE) begin
      sys_ext_ff <= clksel_ff == `EOC_CLKSEL_EXT;
    end
  end

  // ****************************************************************
  // Pin ownership
  // ****************************************************************
  // R4 crystal takes both
  // R5 RC and CMOS modes second only, off mode neither
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_one_ff <= 1'b0;
      pin_two_ff <= 1'b0;
    end else if (CE) begin
      pin_one_ff <= kind == EOC_KIND_XTAL;
      pin_two_ff <= kind != EOC_KIND_OFF;
    end
  end

  // ****************************************************************
  // Crystal start-up
  // ****************************************************************
  // The settle detector is analog, so it is captured like any pin
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      a1_ff <= 1'b0;
      a2_ff <= 1'b0;
      a3_ff <= 1'b0;
    end else if (CE) begin
      a1_ff <= AMP_SETTLED;
      a2_ff <= a1_ff;
      a3_ff <= a2_ff;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      amp_ff <= 1'b0;
    end else if (CE && a2_ff == a3_ff) begin
      amp_ff <= a3_ff;
    end
  end

  // R15 valid on settle
  // Only leaving crystal mode clears the flag; settling in the same cycle
  // as a rewrite that keeps crystal mode still reaches the valid state
  always_comb begin
    nxt_xst = xst_ff;
    unique case (xst_ff)
      EOC_XS_IDLE: begin
        if (kind == EOC_KIND_XTAL) begin
          nxt_xst = EOC_XS_WAIT;
        end
      end
      EOC_XS_WAIT: begin
        if (kind != EOC_KIND_XTAL) begin
          nxt_xst = EOC_XS_IDLE;
        end else if (amp_ff) begin
          nxt_xst = EOC_XS_VALID;
        end
      end
      EOC_XS_VALID: begin
        if (kind != EOC_KIND_XTAL) begin
          nxt_xst = EOC_XS_IDLE;
        end
      end
      default: begin
        nxt_xst = EOC_XS_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      xst_ff <= EOC_XS_IDLE;
    end else if (CE) begin
      xst_ff <= nxt_xst;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    xctl_img.crystal_valid_flag = xst_ff == EOC_XS_VALID;
    xctl_img.ext_osc_type_select = type_ff;
    xctl_img.spare = 1'b0;
    xctl_img.ext_freq_control = freq_ff;
    nxt_rdata = `EOC_RD_NONE;
    if (SFR_REQ.addr == `EOC_ADDR_CAL) begin
      // R2 undefined under recovery
      nxt_rdata = CLOCK_RECOVERY_EN ? `EOC_RD_NONE : {3'h0, trim_ff};
    end else if (SFR_REQ.addr == `EOC_ADDR_XCTL) begin
      nxt_rdata = xctl_img;
    end else if (SFR_REQ.addr == `EOC_ADDR_CLKSEL) begin
      nxt_rdata = {6'h00, clksel_ff};
    end
  end

  // Data is held until the next read so a slow core may sample late
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= `EOC_RD_NONE;
    end else if (CE && SFR_REQ.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Divided clock for timers and counter array
  // ****************************************************************
  // R8 peripheral clock option
  eoc_ext_div i_eoc_ext_div (
    .clk(MCLK),
    .rst_n(RSTN),
    .ce(CE),
    .ext_clk_pin(EXT_OSC_CLK),
    .run(pin_two_ff),
    .tick(div_tick)
  );

  assign OSCILLATOR_TRIM_FIELD = trim_ff;
  assign EXT_OSC_TYPE_SELECT = type_ff;
  assign EXT_FREQ_CONTROL = freq_ff;
  assign OSC_PIN_ONE_CLAIM = pin_one_ff;
  assign OSC_PIN_TWO_CLAIM = pin_two_ff;
  assign SYSCLK_FROM_EXT = sys_ext_ff;
  assign EXT_DIV8_TICK = div_tick;
  assign SFR_RDATA = rdata_ff;

endmodule : eoc_top

//--- include/eoc_cfg.svh
`ifndef EOC_CFG_SVH
`define EOC_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EOC_ADDR_CAL 8'hB3
// Offsets of the two added registers are arbitrary, free slots of the map
`define EOC_ADDR_XCTL 8'hC0
`define EOC_ADDR_CLKSEL 8'hC1

// ****************************************************************
// Field positions
// ****************************************************************
`define EOC_CAL_MSB 4
`define EOC_XCTL_VALID_BIT 7
`define EOC_XCTL_TYPE_MSB 6
`define EOC_XCTL_TYPE_LSB 4
`define EOC_XCTL_FREQ_MSB 2
`define EOC_XCTL_FREQ_LSB 0
`define EOC_CLKSEL_MSB 1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define EOC_CAL_RESET 5'h10
`define EOC_TYPE_RESET 3'h0
`define EOC_FREQ_RESET 3'h0
`define EOC_CLKSEL_RESET 2'h0
`define EOC_CLKSEL_EXT 2'h1
`define EOC_RD_NONE 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define EOC_DIV_LAST 3'h7

`endif

//--- include/eoc_pkg.sv
package eoc_pkg;

  // Decoded oscillator type
  typedef enum logic [1:0] {
    EOC_KIND_OFF = 2'b00,
    EOC_KIND_CMOS = 2'b01,
    EOC_KIND_RC = 2'b10,
    EOC_KIND_XTAL = 2'b11
  } eoc_kind_t;

  // Crystal start-up states
  typedef enum logic [1:0] {
    EOC_XS_IDLE = 2'b00,
    EOC_XS_WAIT = 2'b01,
    EOC_XS_VALID = 2'b10
  } eoc_xst_t;

  // Byte image of the external oscillator control register
  typedef struct packed {
    logic crystal_valid_flag;
    logic [2:0] ext_osc_type_select;
    logic spare;
    logic [2:0] ext_freq_control;
  } eoc_xctl_t;

  // Register access strobes with their data
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } eoc_sfr_req_t;

  // Type field decode: 11x crystal, 10x RC or capacitor, 01x CMOS clock
  function automatic eoc_kind_t eoc_kind(input logic [2:0] type_sel);
    eoc_kind_t k;
    k = EOC_KIND_OFF;
    if (type_sel[2:1] == 2'b11) begin
      k = EOC_KIND_XTAL;
    end else if (type_sel[2:1] == 2'b10) begin
      k = EOC_KIND_RC;
    end else if (type_sel[2:1] == 2'b01) begin
      k = EOC_KIND_CMOS;
    end
    return k;
  endfunction : eoc_kind

endpackage : eoc_pkg

//--- tb/eoc_osc_model.sv
`timescale 1ns/1ps
// ****
// External oscillator
// ****
module eoc_osc_model #(
  parameter int HALF_NS = 20,
  parameter int SETTLE_NS = 300
) (
  // Pin claims
  input wire logic pin_one_claim,
  input wire logic pin_two_claim,
  // Oscillator outputs
  output logic ext_clk,
  output logic amp_settled
);
  int held_ns;
  // pin use: only the oscillator drives a claimed pin, a plain input
  initial begin
    ext_clk = 1'b0;
    forever begin
      #HALF_NS;
      ext_clk = pin_two_claim ? ~ext_clk : 1'b0;
    end
  end
  // Amplitude builds only while the crystal pins stay claimed, so early polls see zero
  initial begin
    amp_settled = 1'b0;
    held_ns = 0;
    forever begin
      #1;
      if (!pin_one_claim) begin
        held_ns = 0;
      end else if (held_ns < SETTLE_NS) begin
        held_ns++;
      end
      amp_settled = held_ns >= SETTLE_NS;
    end
  end
endmodule : eoc_osc_model

//--- tb/eoc_top_bench.sv
`timescale 1ns/1ps
`include "eoc_cfg.svh"
module eoc_top_bench;
  import eoc_pkg::*;
  logic clk, rstn, ce, rec, xclk, amp, p1, p2, sysx, tick;
  eoc_sfr_req_t req;
  logic [7:0] rdata;
  logic [4:0] trim;
  logic [2:0] typ, frq;
  int fail_count, n_tests, n;
  eoc_top i_eoc_top (.MCLK(clk), .RSTN(rstn), .CE(ce), .SFR_REQ(req), .SFR_RDATA(rdata),
    .EXT_OSC_CLK(xclk), .AMP_SETTLED(amp), .CLOCK_RECOVERY_EN(rec),
    .OSCILLATOR_TRIM_FIELD(trim), .EXT_OSC_TYPE_SELECT(typ), .EXT_FREQ_CONTROL(frq),
    .OSC_PIN_ONE_CLAIM(p1), .OSC_PIN_TWO_CLAIM(p2), .SYSCLK_FROM_EXT(sysx),
    .EXT_DIV8_TICK(tick));
  eoc_osc_model i_eoc_osc_model (.pin_one_claim(p1), .pin_two_claim(p2), .ext_clk(xclk),
    .amp_settled(amp));
  // ****
  // Clock and tasks
  // ****
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk(rdata, exp, what);
  endtask : rd
  // Cycles from one tick to the next, bounded
  task automatic gap(output int c);
    c = 0;
    @(negedge clk iff tick === 1'b1);
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'b1 && c < 200);
  endtask : gap
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #20us;
    fail_count++;
    end_sim();
  end
  // ****
  // Tests
  // ****
  initial begin
    fail_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    ce = 1'b1;
    rec = 1'b0;
    req = '0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk({3'h0, trim}, 8'h10, "trim");
    rd(`EOC_ADDR_CAL, 8'h10, "cal");
    rd(`EOC_ADDR_XCTL, 8'h00, "xctl");
    rd(`EOC_ADDR_CLKSEL, 8'h00, "clksel");
    wr(8'hB2, 8'hFF);
    rd(8'hB2, 8'h00, "unmapped");
    $display("reset test done");
    wr(`EOC_ADDR_CAL, 8'hFF);
    chk({3'h0, trim}, 8'h1F, "trim");
    rd(`EOC_ADDR_CAL, 8'h1F, "cal");
    ce = 1'b0;
    wr(`EOC_ADDR_CAL, 8'h05);
    ce = 1'b1;
    rd(`EOC_ADDR_CAL, 8'h1F, "cal frozen");
    rec = 1'b1;
    rd(`EOC_ADDR_CAL, 8'h00, "cal recovery");
    rec = 1'b0;
    rd(`EOC_ADDR_CAL, 8'h1F, "cal");
    $display("trim test done");
    for (int t = 0; t < 8; t++) begin
      wr(`EOC_ADDR_XCTL, {1'b0, t[2:0], 4'hF});
      @(negedge clk);
      chk({5'h00, typ}, {5'h00, t[2:0]}, "type");
      chk({5'h00, frq}, 8'h07, "freq");
      chk({7'h0, p1}, {7'h0, t[2:1] == 2'b11}, "pin one");
      chk({7'h0, p2}, {7'h0, t[2:1] != 2'b00}, "pin two");
      rd(`EOC_ADDR_XCTL, {1'b0, t[2:0], 4'h7}, "xctl");
    end
    $display("mode test done");
    wr(`EOC_ADDR_XCTL, 8'h00);
    wr(`EOC_ADDR_XCTL, 8'h67);
    rd(`EOC_ADDR_XCTL, 8'h67, "early flag");
    repeat (100) @(negedge clk);
    rd(`EOC_ADDR_XCTL, 8'hE7, "settled flag");
    wr(`EOC_ADDR_CLKSEL, 8'h01);
    @(negedge clk);
    chk({7'h0, sysx}, 8'h01, "sysclk ext");
    wr(`EOC_ADDR_CLKSEL, 8'h03);
    @(negedge clk);
    chk({7'h0, sysx}, 8'h00, "sysclk rsvd");
    wr(`EOC_ADDR_CLKSEL, 8'h00);
    $display("crystal test done");
    wr(`EOC_ADDR_XCTL, 8'h47);
    rd(`EOC_ADDR_XCTL, 8'h47, "flag cleared");
    gap(n);
    gap(n);
    chk(n[7:0], 8'h40, "tick gap");
    gap(n);
    chk(n[7:0], 8'h40, "tick gap");
    wr(`EOC_ADDR_XCTL, 8'h00);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (tick !== 1'b0) n++;
    end
    chk(n[7:0], 8'h00, "tick off");
    $display("divider test done");
    // A reset in mid-run must drop the claims and restore the trim
    wr(`EOC_ADDR_XCTL, 8'h67);
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk({6'h00, p1, p2}, 8'h00, "claims after reset");
    rd(`EOC_ADDR_XCTL, 8'h00, "xctl after reset");
    rd(`EOC_ADDR_CAL, 8'h10, "cal after reset");
    $display("second reset test done");
    end_sim();
  end
endmodule : eoc_top_bench

//--- tb/eoc_top_monitor.sv
`timescale 1ns/1ps
`include "eoc_cfg.svh"
// ****
// Port checker
// ****
module eoc_top_monitor (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  // Register access
  input wire eoc_pkg::eoc_sfr_req_t SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  input wire logic CLOCK_RECOVERY_EN,
  // Controls
  input wire logic [4:0] OSCILLATOR_TRIM_FIELD,
  input wire logic [2:0] EXT_OSC_TYPE_SELECT,
  input wire logic OSC_PIN_ONE_CLAIM,
  input wire logic OSC_PIN_TWO_CLAIM,
  input wire logic SYSCLK_FROM_EXT,
  input wire logic EXT_DIV8_TICK
);
  import eoc_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  logic wr_cal, rd_cal, wr_sel, tk;
  assign wr_cal = CE && SFR_REQ.wr && SFR_REQ.addr == `EOC_ADDR_CAL;
  assign rd_cal = CE && SFR_REQ.rd && SFR_REQ.addr == `EOC_ADDR_CAL;
  assign wr_sel = CE && SFR_REQ.wr && SFR_REQ.addr == `EOC_ADDR_CLKSEL;
  assign tk = EXT_DIV8_TICK;
  a_trim_write: assert property (wr_cal |=>
    OSCILLATOR_TRIM_FIELD == $past(SFR_REQ.wdata[4:0])) else $error("trim not stored");
  a_cal_read: assert property (rd_cal && !CLOCK_RECOVERY_EN |=>
    SFR_RDATA == {3'h0, $past(OSCILLATOR_TRIM_FIELD)}) else $error("trim read wrong");
  a_cal_hidden: assert property (rd_cal && CLOCK_RECOVERY_EN |=>
    SFR_RDATA == 8'h00) else $error("trim read during recovery");
  a_xtal_pins: assert property (CE |=> OSC_PIN_ONE_CLAIM ==
    $past(EXT_OSC_TYPE_SELECT[2:1] == 2'b11)) else $error("pin one claim wrong");
  a_rc_pin: assert property (CE |=> OSC_PIN_TWO_CLAIM ==
    $past(EXT_OSC_TYPE_SELECT[2:1] != 2'b00)) else $error("pin two claim wrong");
  a_sysclk_ext: assert property (wr_sel ##1 CE |=> SYSCLK_FROM_EXT ==
    ($past(SFR_REQ.wdata[1:0], 2) == 2'h1)) else $error("clock select wrong");
  a_tick_pulse: assert property (tk && CE |=> !tk) else $error("tick too long");
  a_tick_gap: assert property (tk && CE |=> !tk [*8]) else $error("ticks too close");
  a_tick_mode: assert property (tk |->
    OSC_PIN_TWO_CLAIM || $past(OSC_PIN_TWO_CLAIM)) else $error("tick with pin free");
  c_tick: cover property (tk);
  c_xtal: cover property (OSC_PIN_ONE_CLAIM);
  c_sysext: cover property (SYSCLK_FROM_EXT);
endmodule : eoc_top_monitor

bind eoc_top eoc_top_monitor i_eoc_top_monitor (.MCLK, .RSTN, .CE, .SFR_REQ, .SFR_RDATA,
  .CLOCK_RECOVERY_EN, .OSCILLATOR_TRIM_FIELD, .EXT_OSC_TYPE_SELECT, .OSC_PIN_ONE_CLAIM,
  .OSC_PIN_TWO_CLAIM, .SYSCLK_FROM_EXT, .EXT_DIV8_TICK);
